/* logic/chan_iface.sv */
// device-side bus logic: interrupt acknowledge and data-channel slave
module chan_iface
    import chan_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire bus_ctl_s          bus_pins,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic      [DATA_W-1:0] data_oe_n,
    output logic                   chan_request_line,
    output logic                   chan_priority_out,
    output logic                   chan_direction_mode,
    output logic                   map_ext_select,
    input  wire logic              irq_request,
    input  wire logic [CODE_W-1:0] dev_code,
    input  wire logic              xfer_want,
    input  wire logic              back_to_back,
    input  wire logic              dir_input,
    input  wire logic              map_enable,
    input  wire logic              map_bit0,
    input  wire logic              map_ext_bit,
    input  wire logic [DATA_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] in_word,
    output logic      [DATA_W-1:0] out_word,
    output logic                   out_word_valid,
    output logic                   in_word_taken,
    output logic                   selected,
    output logic                   requesting
);
    // two-stage synchronisers for every bus pin input
    bus_ctl_s          pins_s1_reg;
    bus_ctl_s          pins_s2_reg;
    bus_ctl_s          pins_prev_reg;
    logic [DATA_W-1:0] data_s1_reg;
    logic [DATA_W-1:0] data_s2_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pins_s1_reg   <= '0;
            pins_s2_reg   <= '0;
            pins_prev_reg <= '0;
            data_s1_reg   <= DATA_ZERO;
            data_s2_reg   <= DATA_ZERO;
        end
        else if (ce)
        begin
            pins_s1_reg   <= bus_pins;
            pins_s2_reg   <= pins_s1_reg;
            pins_prev_reg <= pins_s2_reg;
            data_s1_reg   <= data_in;
            data_s2_reg   <= data_s1_reg;
        end
    end

    wire bus_ctl_s pins = pins_s2_reg;

    // edge detection on synchronised strobes only
    wire request_enable_strobe_rise = pins.request_enable_strobe & ~pins_prev_reg.request_enable_strobe;
    wire ack_rise   = pins.chan_ack_strobe & ~pins_prev_reg.chan_ack_strobe;
    wire out_fall   = ~pins.chan_output_strobe & pins_prev_reg.chan_output_strobe;
    wire in_fall    = ~pins.chan_input_strobe & pins_prev_reg.chan_input_strobe;
    wire bus_clear  = pins.bus_reset_pulse;

    logic        sync_reg;
    logic        sync_next;
    logic        req_reg;
    logic        req_next;
    logic        sel_reg;
    logic        sel_next;
    logic        dir_reg;
    chan_state_e state_reg;
    chan_state_e state_next;

    // a new request from the user wins over the acknowledge clear in the same cycle
    wire sync_clr = ack_rise & sel_next & ~back_to_back;
    assign sync_next = bus_clear ? SYNC_RST
                     : xfer_want ? 1'b1
                     : sync_clr ? 1'b0
                     : sync_reg;
    assign req_next  = bus_clear ? REQ_RST
                     : request_enable_strobe_rise ? sync_reg
                     : req_reg;
    // selection captured only at acknowledge leading edge; priority in is low-true
    wire   win       = req_reg & ~pins.chan_priority_in;
    assign sel_next  = bus_clear ? SEL_RST
                     : ack_rise ? win
                     : sel_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_reg <= SYNC_RST;
            req_reg  <= REQ_RST;
            sel_reg  <= SEL_RST;
        end
        else if (ce)
        begin
            sync_reg <= sync_next;
            req_reg  <= req_next;
            sel_reg  <= sel_next;
        end
    end

    // transfer direction is frozen at the acknowledge so a late user change cannot flip it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dir_reg <= MODE_OUTPUT;
        else if (ce && ack_rise)
            dir_reg <= dir_input ? MODE_INPUT : MODE_OUTPUT;
    end

    // cycle tracker: idle, acknowledge phase, data phase
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (ack_rise) state_next = ST_ACK;
            ST_ACK:  if (!pins.chan_ack_strobe) state_next = ST_XFER;
            ST_XFER: if (ack_rise) state_next = ST_ACK;
            default: state_next = ST_IDLE;
        endcase
        if (bus_clear)
            state_next = ST_IDLE;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_reg <= ST_IDLE;
        else if (ce)
            state_reg <= state_next;
    end

    // strobe gating by the selected flag
    wire sel_act   = sel_reg & ~bus_clear;
    // the fresh selection decides at the leading edge, so a stale flag never drives
    wire drv_ack   = sel_next & pins.chan_ack_strobe;
    wire dir_now   = ack_rise ? (dir_input ? MODE_INPUT : MODE_OUTPUT) : dir_reg;
    wire drv_in    = sel_act & pins.chan_input_strobe
                   & (dir_reg == MODE_INPUT) & (state_reg == ST_XFER);
    wire take_out  = sel_act & out_fall & (dir_reg == MODE_OUTPUT);
    wire took_in   = sel_act & in_fall & (dir_reg == MODE_INPUT);
    // interrupt acknowledge ignores device select; priority in is low-true
    wire drv_intr_ack_strobe  = pins.intr_ack_strobe & ~pins.irq_priority_in & irq_request;

    // map bit 0 rides on the address word during acknowledge
    wire [DATA_W-1:0] ack_word  = map_enable ? {map_bit0, mem_addr[DATA_W-2:0]}
                                             : mem_addr;
    wire [DATA_W-1:0] intr_ack_strobe_word = {{(DATA_W-CODE_W){1'b0}}, dev_code};
    wire [DATA_W-1:0] intr_ack_strobe_mask = {{(DATA_W-CODE_W){1'b0}}, {CODE_W{1'b1}}};
    // bus bit 0 is the msb; code bits 10-15 are the low six
    wire [DATA_W-1:0] word_next = drv_ack ? ack_word
                                : drv_in ? in_word
                                : drv_intr_ack_strobe ? intr_ack_strobe_word
                                : DATA_ZERO;
    wire [DATA_W-1:0] oe_n_next = (drv_ack | drv_in) ? DATA_ZERO
                                : drv_intr_ack_strobe ? ~intr_ack_strobe_mask
                                : ~DATA_ZERO;
    // priority out is high when we request or when upstream already blocks
    wire prio_next = req_next | pins.chan_priority_in;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            data_out            <= DATA_ZERO;
            data_oe_n           <= ~DATA_ZERO;
            chan_request_line   <= REQ_RST;
            chan_priority_out   <= 1'b0;
            chan_direction_mode <= MODE_OUTPUT;
            map_ext_select      <= 1'b0;
            out_word            <= DATA_ZERO;
            out_word_valid      <= 1'b0;
            in_word_taken       <= 1'b0;
            selected            <= SEL_RST;
            requesting          <= REQ_RST;
        end
        else if (ce)
        begin
            data_out            <= word_next;
            data_oe_n           <= oe_n_next;
            chan_request_line   <= req_next;
            chan_priority_out   <= prio_next;
            chan_direction_mode <= sel_next & dir_now;
            map_ext_select      <= drv_ack & map_enable & map_ext_bit;
            out_word_valid      <= take_out;
            in_word_taken       <= took_in;
            selected            <= sel_next;
            requesting          <= req_next;
            if (take_out)
                out_word <= data_s2_reg;
        end
    end
endmodule

/* logic/chan_pkg.sv */
// package: widths, codes and grouped bus signals for the data-channel interface
package chan_pkg;
    localparam int          DATA_W        = 16;
    localparam int          CODE_W        = 6;
    localparam int          CODE_LSB      = 10;
    localparam logic        SYNC_RST      = 1'b0;
    localparam logic        REQ_RST       = 1'b0;
    localparam logic        SEL_RST       = 1'b0;
    localparam logic        MODE_OUTPUT   = 1'b0;
    localparam logic        MODE_INPUT    = 1'b1;
    localparam logic [15:0] DATA_ZERO     = 16'h0000;
    localparam logic [5:0]  DEV_CODE_DEF  = 6'h15;

    typedef struct packed {
        logic intr_ack_strobe;
        logic request_enable_strobe;
        logic chan_ack_strobe;
        logic chan_input_strobe;
        logic chan_output_strobe;
        logic bus_reset_pulse;
        logic irq_priority_in;
        logic chan_priority_in;
    } bus_ctl_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACK  = 3'b010,
        ST_XFER = 3'b100
    } chan_state_e;
endpackage

/* bench/cpu_model.sv */
// processor-side bus model: strobes, priority inputs and data lines
module cpu_model
    import chan_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] dev_data,
    input  wire logic [DATA_W-1:0] dev_oe_n,
    output bus_ctl_s               pins,
    output logic      [DATA_W-1:0] bus_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] word = '0;
    logic [DATA_W-1:0] held = '1;
    logic [DATA_W-1:0] acc  = '0;
    logic              drv  = 1'b0;
    // released lines show the inverse of the last word so a stale value never matches
    assign bus_data = drv ? word : (~dev_oe_n & dev_data) | (dev_oe_n & held);
    initial
        pins = '0;
    task set(input int idx, input logic v);
        @(negedge clk);
        pins[idx] = v;
    endtask
    task drive(input logic on, input logic [DATA_W-1:0] w);
        @(negedge clk);
        drv  = on;
        word = w;
        held = ~w;
    endtask
    always @(negedge pins.intr_ack_strobe)
        acc = bus_data;
endmodule

/* bench/chan_iface_checker.sv */
// checker: port relations of the data-channel interface
module chan_iface_checker
    import chan_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst,
    input  wire bus_ctl_s bus_pins,
    input  wire logic     chan_request_line,
    input  wire logic     chan_priority_out,
    input  wire logic     chan_direction_mode,
    input  wire logic     map_ext_select,
    input  wire logic     out_word_valid,
    input  wire logic     in_word_taken,
    input  wire logic     selected,
    input  wire logic     requesting
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking dck @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] en_age;
    // saturating age so a long-gone enable never looks recent
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            en_age <= 4'hF;
        else if (bus_pins.request_enable_strobe | bus_pins.bus_reset_pulse)
            en_age <= 4'h0;
        else
            en_age <= en_age + {3'h0, en_age != 4'hF};
    end
    req_on_enable_a: assert property ($changed(chan_request_line) |-> en_age <= 4'h6)
        else $error("request moved without enable");
    prio_block_a: assert property ($rose(chan_request_line) |-> ##[0:2] chan_priority_out)
        else $error("priority out not raised");
    sel_cause_a: assert property ($rose(selected) |-> requesting || $past(requesting))
        else $error("selected without request");
    dir_idle_a: assert property (!selected && !$past(selected) |-> !chan_direction_mode)
        else $error("mode driven while unselected");
    taken_sel_a: assert property (in_word_taken |-> selected && chan_direction_mode)
        else $error("input word taken while unselected");
    valid_sel_a: assert property (out_word_valid |-> selected && !chan_direction_mode)
        else $error("output word latched while unselected");
    map_sel_a: assert property (map_ext_select |-> selected)
        else $error("map select while unselected");
    reset_clr_a: assert property (bus_pins.bus_reset_pulse [*6] |-> !selected && !requesting)
        else $error("bus reset left channel state");
endmodule
bind chan_iface chan_iface_checker u_chan_iface_checker (.clk, .rst, .bus_pins,
    .chan_request_line, .chan_priority_out, .chan_direction_mode, .map_ext_select,
    .out_word_valid, .in_word_taken, .selected, .requesting);

/* bench/chan_iface_tb.sv */
// bench: interrupt acknowledge and data-channel transfers against the processor model
module chan_iface_tb import chan_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk = 1'b0, rst = 1'b1, irq_request, xfer_want, back_to_back, dir_input;
    logic              map_enable, map_bit0, map_ext_bit, chan_request_line, chan_priority_out;
    logic              chan_direction_mode, map_ext_select, out_word_valid, in_word_taken;
    logic              selected, requesting;
    logic [CODE_W-1:0] dev_code;
    logic [DATA_W-1:0] data_in, data_out, data_oe_n, mem_addr, in_word, out_word;
    bus_ctl_s          bus_pins;
    int                n_fail = 0, check_count = 0, i;
    chan_iface u_chan_iface (.clk, .rst, .ce(1'b1), .bus_pins, .data_in, .data_out, .data_oe_n,
        .chan_request_line, .chan_priority_out, .chan_direction_mode, .map_ext_select,
        .irq_request, .dev_code, .xfer_want, .back_to_back, .dir_input, .map_enable, .map_bit0,
        .map_ext_bit, .mem_addr, .in_word, .out_word, .out_word_valid, .in_word_taken,
        .selected, .requesting);
    cpu_model u_cpu_model (.clk, .dev_data(data_out), .dev_oe_n(data_oe_n), .pins(bus_pins),
        .bus_data(data_in));
    initial
        forever #12.5 clk = ~clk;
    task chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // pins pass two sync stages and an edge detect, so six cycles covers the answer
    task pin(input int idx, input logic v);
        u_cpu_model.set(idx, v);
        repeat (6) @(negedge clk);
    endtask
    initial
    begin
        {irq_request, xfer_want, back_to_back, dir_input, map_enable, map_bit0, map_ext_bit} = '0;
        dev_code = 6'h2D;
        mem_addr = 16'h1234;
        in_word  = 16'hA5C3;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk("oe_rst", data_oe_n, 16'hFFFF);
        irq_request = 1'b1;
        pin(7, 1'b1);
        chk("code", data_out[5:0], dev_code);
        chk("code_oe", data_oe_n[5:0], 6'h00);
        pin(7, 1'b0);
        chk("code_acc", u_cpu_model.acc[5:0], dev_code);
        pin(1, 1'b1);
        pin(7, 1'b1);
        chk("code_blocked", data_oe_n, 16'hFFFF);
        pin(7, 1'b0);
        pin(1, 1'b0);
        {irq_request, xfer_want, dir_input} = 3'b011;
        repeat (6) @(negedge clk);
        chk("req_wait", chan_request_line, 1'b0);
        pin(6, 1'b1);
        pin(6, 1'b0);
        chk("req", chan_request_line, 1'b1);
        chk("prio", chan_priority_out, 1'b1);
        xfer_want = 1'b0;
        pin(5, 1'b1);
        chk("sel", selected, 1'b1);
        chk("addr", data_out, mem_addr);
        chk("addr_oe", data_oe_n, 16'h0000);
        chk("dir_in", chan_direction_mode, MODE_INPUT);
        pin(5, 1'b0);
        pin(4, 1'b1);
        chk("in_word", data_out, in_word);
        u_cpu_model.set(4, 1'b0);
        for (i = 0; i < 20 && in_word_taken !== 1'b1; i++)
            @(negedge clk);
        chk("in_taken", in_word_taken, 1'b1);
        repeat (4) @(negedge clk);
        pin(6, 1'b1);
        pin(6, 1'b0);
        chk("req_off", chan_request_line, 1'b0);
        chk("prio_free", chan_priority_out, 1'b0);
        pin(5, 1'b1);
        chk("unsel", selected, 1'b0);
        pin(5, 1'b0);
        pin(4, 1'b1);
        chk("ignored", data_oe_n, 16'hFFFF);
        pin(4, 1'b0);
        pin(0, 1'b1);
        chk("prio_chain", chan_priority_out, 1'b1);
        {xfer_want, dir_input, map_enable, map_bit0, map_ext_bit} = 5'b10111;
        pin(6, 1'b1);
        pin(6, 1'b0);
        pin(5, 1'b1);
        chk("blocked", selected, 1'b0);
        pin(5, 1'b0);
        pin(0, 1'b0);
        pin(5, 1'b1);
        chk("map_addr", data_out, 16'h9234);
        chk("map_ext", map_ext_select, 1'b1);
        chk("dir_out", chan_direction_mode, MODE_OUTPUT);
        pin(5, 1'b0);
        u_cpu_model.drive(1'b1, 16'h5A3C);
        pin(3, 1'b1);
        u_cpu_model.set(3, 1'b0);
        for (i = 0; i < 20 && out_word_valid !== 1'b1; i++)
            @(negedge clk);
        if (i == 20)
        begin
            n_fail++;
            end_of_test;
        end
        chk("out_word", out_word, 16'h5A3C);
        u_cpu_model.drive(1'b0, 16'h0000);
        pin(2, 1'b1);
        chk("rst_req", chan_request_line, 1'b0);
        chk("rst_sel", selected, 1'b0);
        pin(2, 1'b0);
        end_of_test;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_of_test;
    end
endmodule
